// ### shared/spr_consts.vh
// Constants for the setpoint relay controller
`ifndef SPR_CONSTS_VH
`define SPR_CONSTS_VH
`define SPR_CLK_HZ        25000000
`define SPR_SEC_CYCLES    (`SPR_CLK_HZ)
`define SPR_SEC_LAST      25'h17D783F
`define SPR_DELAY_MAX     14'h270F
`define SPR_VAL_HI        16'sh270F
`define SPR_VAL_LO        -16'sh07CF
`define SPR_ST_OPER       4'h0
`define SPR_ST_SP1        4'h1
`define SPR_ST_MAKE       4'h2
`define SPR_ST_BREAK      4'h3
`define SPR_ST_HYS1       4'h4
`define SPR_ST_PUMP       4'h5
`define SPR_ST_SP2        4'h6
`define SPR_ST_HYS2       4'h7
`define SPR_ST_SP3        4'h8
`define SPR_ST_HYS3       4'h9
`define SPR_ST_SP4        4'hA
`define SPR_ST_HYS4       4'hB
`define SPR_ST_PAT        4'hC
`define SPR_ST_COLOR      4'hD
`define SPR_RST_SP        16'sh0000
`define SPR_RST_DELAY     14'h0000
`define SPR_RST_PATTERN   4'hF
`define SPR_HYS_BAND      16'sh000A
`endif

// ### hdl/spr_setpoint_relay_controller.v
// Setpoint comparison, relay timing and setpoint menu sequencing
`timescale 1ns/1ps
`default_nettype none
`include "spr_consts.vh"
module spr_setpoint_relay_controller (
  input  wire               clk_sys_i,
  input  wire               rstn_i,
  input  wire signed [15:0] reading_i,
  input  wire               btn_prog_i,
  input  wire               btn_up_i,
  input  wire               btn_down_i,
  input  wire               lock_n_i,
  input  wire               tricolor_fitted_i,
  output reg  [3:0]         relay_o,
  output reg  [3:0]         annunciator_o,
  output reg  [3:0]         menu_state_o,
  output reg  [1:0]         pattern_digit_o,
  output reg  signed [15:0] shown_value_o,
  output reg                color_menu_o
);
  // Button and lock inputs, two-stage synchronisers
  reg [4:1] sync_a;
  reg [4:1] sync_b;
  reg [4:1] prev_b;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
      prev_b <= 4'hF;
    end else begin
      sync_a <= {lock_n_i, btn_down_i, btn_up_i, btn_prog_i};
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end
  wire prog_lvl = sync_b[1];
  wire up_lvl   = sync_b[2];
  wire prog_p   = sync_b[1] & ~prev_b[1];
  wire up_p     = sync_b[2] & ~prev_b[2];
  wire down_p   = sync_b[3] & ~prev_b[3];
  wire locked   = ~sync_b[4];
  // Lock only blocks edits, never navigation
  wire edit_ok  = ~locked;

  // One-second enable for the delay timers
  reg [24:0] sec_cnt;
  wire       sec_tick = (sec_cnt == 25'd0);
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      sec_cnt <= 25'd0;
    else if (sec_tick)
      sec_cnt <= `SPR_SEC_LAST;
    else
      sec_cnt <= sec_cnt - 25'd1;
  end

  // Stored parameters
  reg signed [15:0] sp [0:3];
  reg [13:0]        make_delay;
  reg [13:0]        break_delay;
  reg [3:0]         hysteresis_select;
  reg               pump_band_select;
  reg [3:0]         relay_activation_pattern; // bit0 = setpoint one, 1 = high
  reg [3:0]         state;
  reg [1:0]         pdig;

  function signed [15:0] bump_sp;
    input signed [15:0] v;
    input               up;
    input               dn;
    begin
      if (up && v < `SPR_VAL_HI)
        bump_sp = v + 16'sd1;
      else if (dn && v > `SPR_VAL_LO)
        bump_sp = v - 16'sd1;
      else
        bump_sp = v;
    end
  endfunction
  function [13:0] bump_dly;
    input [13:0] v;
    input        up;
    input        dn;
    begin
      if (up && v < `SPR_DELAY_MAX)
        bump_dly = v + 14'd1;
      else if (dn && v != 14'd0)
        bump_dly = v - 14'd1;
      else
        bump_dly = v;
    end
  endfunction

  wire chg = (up_p | down_p) & edit_ok;
  integer k;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (k = 0; k < 4; k = k + 1)
        sp[k] <= `SPR_RST_SP;
      make_delay <= `SPR_RST_DELAY;
      break_delay <= `SPR_RST_DELAY;
      hysteresis_select <= 4'h0;
      pump_band_select <= 1'b0;
      relay_activation_pattern <= `SPR_RST_PATTERN;
      state <= `SPR_ST_OPER;
      pdig <= 2'd0;
    end else begin
      case (state)
        `SPR_ST_OPER: begin
          if (prog_lvl && up_lvl && (prog_p || up_p))
            state <= `SPR_ST_SP1;
        end
        `SPR_ST_SP1: begin
          if (chg) sp[0] <= bump_sp(sp[0], up_p, down_p);
          if (prog_p) state <= `SPR_ST_MAKE;
        end
        `SPR_ST_MAKE: begin
          if (chg) make_delay <= bump_dly(make_delay, up_p, down_p);
          if (prog_p) state <= `SPR_ST_BREAK;
        end
        `SPR_ST_BREAK: begin
          if (chg) break_delay <= bump_dly(break_delay, up_p, down_p);
          if (prog_p) state <= `SPR_ST_HYS1;
        end
        `SPR_ST_HYS1: begin
          if (chg) hysteresis_select[0] <= up_p;
          if (prog_p) state <= `SPR_ST_PUMP;
        end
        `SPR_ST_PUMP: begin
          if (chg) pump_band_select <= up_p;
          if (prog_p) state <= `SPR_ST_SP2;
        end
        `SPR_ST_SP2: begin
          if (chg) sp[1] <= bump_sp(sp[1], up_p, down_p);
          if (prog_p) state <= `SPR_ST_HYS2;
        end
        `SPR_ST_HYS2: begin
          if (chg) hysteresis_select[1] <= up_p;
          if (prog_p) state <= `SPR_ST_SP3;
        end
        `SPR_ST_SP3: begin
          if (chg) sp[2] <= bump_sp(sp[2], up_p, down_p);
          if (prog_p) state <= `SPR_ST_HYS3;
        end
        `SPR_ST_HYS3: begin
          if (chg) hysteresis_select[2] <= up_p;
          if (prog_p) state <= `SPR_ST_SP4;
        end
        `SPR_ST_SP4: begin
          if (chg) sp[3] <= bump_sp(sp[3], up_p, down_p);
          if (prog_p) state <= `SPR_ST_HYS4;
        end
        `SPR_ST_HYS4: begin
          if (chg) hysteresis_select[3] <= up_p;
          if (prog_p) begin
            state <= `SPR_ST_PAT;
            pdig <= 2'd0;
          end
        end
        `SPR_ST_PAT: begin
          // Up selects high, down selects low
          if (chg) relay_activation_pattern[pdig] <= up_p;
          if (prog_p) begin
            if (pdig == 2'd3)
              state <= tricolor_fitted_i ? `SPR_ST_COLOR
                                         : `SPR_ST_OPER;
            else
              pdig <= pdig + 2'd1;
          end
        end
        `SPR_ST_COLOR: begin
          // Colour settings live elsewhere; a press hands back
          if (prog_p) state <= `SPR_ST_OPER;
        end
        default: state <= `SPR_ST_OPER;
      endcase
    end
  end

  // Alarm evaluation with optional fixed hysteresis band
  reg [3:0] alarm;
  reg [3:0] next_alarm;
  wire pump_on = pump_band_select && (sp[1] > sp[0]);
  integer j;
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      if (relay_activation_pattern[j]) begin
        if (reading_i > sp[j])
          next_alarm[j] = 1'b1;
        else if (!hysteresis_select[j] ||
                 reading_i <= sp[j] - `SPR_HYS_BAND)
          next_alarm[j] = 1'b0;
        else
          next_alarm[j] = alarm[j];
      end else begin
        if (reading_i < sp[j])
          next_alarm[j] = 1'b1;
        else if (!hysteresis_select[j] ||
                 reading_i >= sp[j] + `SPR_HYS_BAND)
          next_alarm[j] = 1'b0;
        else
          next_alarm[j] = alarm[j];
      end
    end
    if (pump_on) begin
      if (!relay_activation_pattern[0]) begin
        if (reading_i < sp[0])
          next_alarm[0] = 1'b1;
        else if (reading_i >= sp[1])
          next_alarm[0] = 1'b0;
        else
          next_alarm[0] = alarm[0];
      end else begin
        if (reading_i > sp[1])
          next_alarm[0] = 1'b1;
        else if (reading_i <= sp[0])
          next_alarm[0] = 1'b0;
        else
          next_alarm[0] = alarm[0];
      end
    end
  end
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      alarm <= 4'h0;
    else
      alarm <= next_alarm;
  end

  // Setpoint one make/break timing
  reg [13:0] dly_cnt;
  reg        relay1;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_cnt <= 14'd0;
      relay1  <= 1'b0;
    end else if (alarm[0] == relay1) begin
      dly_cnt <= 14'd0;
    end else if (alarm[0]) begin
      if (dly_cnt >= make_delay)
        relay1 <= 1'b1;
      else if (sec_tick)
        dly_cnt <= dly_cnt + 14'd1;
    end else begin
      if (dly_cnt >= break_delay)
        relay1 <= 1'b0;
      else if (sec_tick)
        dly_cnt <= dly_cnt + 14'd1;
    end
  end

  // Extreme values in the active direction silence the setpoint
  reg [3:0] quiet;
  integer q;
  always @* begin
    for (q = 0; q < 4; q = q + 1)
      quiet[q] = relay_activation_pattern[q] ? (sp[q] == `SPR_VAL_HI)
                                             : (sp[q] == `SPR_VAL_LO);
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      relay_o <= 4'h0;
      annunciator_o <= 4'h0;
      menu_state_o <= `SPR_ST_OPER;
      pattern_digit_o <= 2'd0;
      shown_value_o <= 16'sd0;
      color_menu_o <= 1'b0;
    end else begin
      relay_o <= {alarm[3:1], relay1} & ~quiet;
      annunciator_o <= {alarm[3:1], relay1} & ~quiet;
      menu_state_o <= state;
      pattern_digit_o <= pdig;
      color_menu_o <= (state == `SPR_ST_COLOR);
      case (state)
        `SPR_ST_SP1:   shown_value_o <= sp[0];
        `SPR_ST_SP2:   shown_value_o <= sp[1];
        `SPR_ST_SP3:   shown_value_o <= sp[2];
        `SPR_ST_SP4:   shown_value_o <= sp[3];
        `SPR_ST_MAKE:  shown_value_o <= {2'b00, make_delay};
        `SPR_ST_BREAK: shown_value_o <= {2'b00, break_delay};
        `SPR_ST_PAT:   shown_value_o <= {12'h000, relay_activation_pattern};
        default:       shown_value_o <= reading_i;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### dv/spr_ctrl_sva.sv
// Port-level assertion checker for the setpoint relay controller
`timescale 1ns/1ps
`default_nettype none
module spr_ctrl_sva (
  input wire               clk_sys_i,
  input wire               rstn_i,
  input wire signed [15:0] reading_i,
  input wire               btn_prog_i,
  input wire               btn_up_i,
  input wire               btn_down_i,
  input wire               lock_n_i,
  input wire               tricolor_fitted_i,
  input wire [3:0]         relay_o,
  input wire [3:0]         annunciator_o,
  input wire [3:0]         menu_state_o,
  input wire [1:0]         pattern_digit_o,
  input wire signed [15:0] shown_value_o,
  input wire               color_menu_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_move;
    $changed(menu_state_o);
  endsequence
  sequence s_locked;
    (!lock_n_i) [*4];
  endsequence
  a_led_follows: assert property (annunciator_o == relay_o)
    else $error("annunciator differs from relay");
  a_code_range: assert property (menu_state_o <= 4'hD)
    else $error("menu code out of range");
  a_entry_step: assert property (
    s_move ##0 $past(menu_state_o) == 4'h0 |-> menu_state_o == 4'h1)
    else $error("menu entry not at first setpoint");
  a_step_order: assert property (
    s_move ##0 $past(menu_state_o) inside {[4'h1:4'hB]}
    |-> menu_state_o == $past(menu_state_o) + 4'h1)
    else $error("menu skipped a step");
  a_digit_step: assert property (
    $changed(pattern_digit_o) && menu_state_o == 4'hC
    && $past(menu_state_o) == 4'hC
    |-> pattern_digit_o == $past(pattern_digit_o) + 2'h1)
    else $error("pattern character skipped");
  a_pattern_exit: assert property (
    s_move ##0 $past(menu_state_o) == 4'hC |-> $past(pattern_digit_o)
    == 2'h3 && menu_state_o == (tricolor_fitted_i ? 4'hD : 4'h0))
    else $error("wrong exit from pattern editing");
  a_color_exit: assert property (
    s_move ##0 $past(menu_state_o) == 4'hD |-> menu_state_o == 4'h0)
    else $error("colour menu exit wrong");
  a_color_flag: assert property (
    color_menu_o == (menu_state_o == 4'hD))
    else $error("colour flag mismatch");
  a_lock_hold: assert property (
    s_locked ##1 (!lock_n_i && menu_state_o == 4'h1
    && $past(menu_state_o) == 4'h1) |-> $stable(shown_value_o))
    else $error("locked value changed");
endmodule
bind spr_setpoint_relay_controller spr_ctrl_sva u_sva (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reading_i(reading_i),
  .btn_prog_i(btn_prog_i), .btn_up_i(btn_up_i), .btn_down_i(btn_down_i),
  .lock_n_i(lock_n_i), .tricolor_fitted_i(tricolor_fitted_i),
  .relay_o(relay_o), .annunciator_o(annunciator_o),
  .menu_state_o(menu_state_o), .pattern_digit_o(pattern_digit_o),
  .shown_value_o(shown_value_o), .color_menu_o(color_menu_o));
`default_nettype wire

// ### dv/spr_panel_model.sv
// Front-panel operator model: buttons and rear lock
`timescale 1ns/1ps
`default_nettype none
module spr_panel_model (
  input  wire logic clk_sys_i,
  output var logic  btn_prog_o,
  output var logic  btn_up_o,
  output var logic  btn_down_o,
  output var logic  lock_n_o
);
  initial begin
    btn_prog_o = 1'b0;
    btn_up_o = 1'b0;
    btn_down_o = 1'b0;
    lock_n_o = 1'b1;
  end
  // Held long enough for the synchroniser, then a quiet gap
  task automatic press(input logic p, u, d, input int hold);
    @(posedge clk_sys_i);
    btn_prog_o <= p;
    btn_up_o <= u;
    btn_down_o <= d;
    repeat (hold) @(posedge clk_sys_i);
    btn_prog_o <= 1'b0;
    btn_up_o <= 1'b0;
    btn_down_o <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic set_lock(input logic n);
    @(posedge clk_sys_i);
    lock_n_o <= n;
    repeat (5) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ### dv/spr_setpoint_relay_controller_tb_top.sv
// Self-checking bench for the setpoint relay controller
`timescale 1ns/1ps
`default_nettype none
module spr_setpoint_relay_controller_tb_top;
  logic               clk_sys_i, rstn_i, tric;
  logic signed [15:0] reading;
  wire                prog, up, down, lock_n, color;
  wire  [3:0]         relay, led, menu;
  wire  [1:0]         digit;
  wire  signed [15:0] shown;
  int                 error_cnt, n_checks, cyc;
  spr_panel_model op (.clk_sys_i(clk_sys_i), .btn_prog_o(prog),
    .btn_up_o(up), .btn_down_o(down), .lock_n_o(lock_n));
  spr_setpoint_relay_controller dut (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .reading_i(reading), .btn_prog_i(prog),
    .btn_up_i(up), .btn_down_i(down), .lock_n_i(lock_n),
    .tricolor_fitted_i(tric), .relay_o(relay), .annunciator_o(led),
    .menu_state_o(menu), .pattern_digit_o(digit),
    .shown_value_o(shown), .color_menu_o(color));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic relays(input logic signed [15:0] r, input logic [3:0] e);
    @(posedge clk_sys_i);
    reading <= r;
    repeat (8) @(posedge clk_sys_i);
    chk("relay", {12'h000, e}, {12'h000, relay});
    chk("annunciator", {12'h000, e}, {12'h000, led});
  endtask
  task automatic leave_menu();
    for (int i = 0; i < 20 && menu !== 4'h0; i++) op.press(1, 0, 0, 4);
    chk("menu idle", 16'h0000, {12'h000, menu});
  endtask
  task automatic t_direct();
    relays(16'sd500, 4'hF);
    chk("shown reading", 16'h01F4, shown);
    relays(-16'sd100, 4'h0);
  endtask
  task automatic t_walk(input logic t);
    @(posedge clk_sys_i);
    tric <= t;
    op.press(1, 1, 0, 4);
    chk("menu entry", 16'h0001, {12'h000, menu});
    for (int i = 2; i <= 12; i++) begin
      op.press(1, 0, 0, 4);
      chk("menu step", 16'(i), {12'h000, menu});
    end
    for (int d = 1; d <= 3; d++) begin
      op.press(1, 0, 0, 4);
      chk("pattern digit", 16'(d), {14'h0000, digit});
    end
    op.press(1, 0, 0, 4);
    chk("after pattern", t ? 16'h000D : 16'h0000, {12'h000, menu});
    chk("colour flag", {15'h0000, t}, {15'h0000, color});
    leave_menu();
    @(posedge clk_sys_i);
    tric <= 1'b0;
  endtask
  task automatic t_lock();
    op.set_lock(0);
    op.press(1, 1, 0, 4);
    op.press(0, 1, 0, 4);
    chk("locked setpoint", 16'h0000, shown);
    leave_menu();
    op.set_lock(1);
  endtask
  task automatic t_edit();
    op.press(1, 1, 0, 4);
    op.press(0, 1, 0, 4);
    chk("raised setpoint", 16'h0001, shown);
    repeat (14) op.press(1, 0, 0, 4);
    op.press(0, 0, 1, 4);
    leave_menu();
    relays(-16'sd100, 4'h8);
    relays(16'sd500, 4'h7);
  endtask
  // Pump band on setpoint one, hysteresis on setpoint three
  task automatic t_pump();
    op.press(1, 1, 0, 4);
    repeat (4) op.press(1, 0, 0, 4);
    op.press(0, 1, 0, 4);
    op.press(1, 0, 0, 4);
    repeat (3) op.press(0, 1, 0, 4);
    chk("setpoint two", 16'h0003, shown);
    repeat (3) op.press(1, 0, 0, 4);
    op.press(0, 1, 0, 4);
    leave_menu();
    relays(16'sd0, 4'h4);
    relays(16'sd2, 4'h4);
    relays(16'sd10, 4'h7);
    relays(16'sd2, 4'h5);
    relays(-16'sd5, 4'hC);
    relays(-16'sd20, 4'h8);
    op.press(1, 1, 0, 4);
    repeat (11) op.press(1, 0, 0, 4);
    op.press(0, 0, 1, 4);
    leave_menu();
    relays(16'sd2, 4'h5);
    relays(16'sd3, 4'h4);
    relays(16'sd2, 4'h4);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    rstn_i = 1'b0;
    tric = 1'b0;
    reading = 16'sd0;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("reset relay", 16'h0000, {12'h000, relay});
    chk("reset menu", 16'h0000, {12'h000, menu});
    t_direct();
    t_walk(0);
    t_walk(1);
    t_lock();
    t_edit();
    t_pump();
    complete_run();
  end
endmodule
`default_nettype wire
